// ==== core/code_ramp.sv ====
// module: walks a voltage code one step at a time toward its target
`timescale 1ns/1ps
module code_ramp #(
  parameter int CNT_W = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  ramp_if.ramp     rp
);
  logic [7:0]       code_reg;
  logic [7:0]       code_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] interval;

  // pace follows the segment of the present code, same up and down
  always_comb begin
    interval  = CNT_W'(regbank_pkg::ramp_interval(code_reg, rp.slew));
    code_next = code_reg;
    cnt_next  = '0;
    if (code_reg != rp.target) begin
      if (cnt_reg >= interval - CNT_W'(1)) begin
        if (code_reg < rp.target) code_next = code_reg + 8'h01;
        else code_next = code_reg - 8'h01;
      end else begin
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= regbank_pkg::VOUT_RESET;
      cnt_reg  <= '0;
    end else begin
      code_reg <= code_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign rp.present = code_reg;
  assign rp.busy    = code_reg != rp.target;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ramp_unit_step: assert property (
    $changed(code_reg) |-> (code_reg == $past(code_reg) + 8'h01) ||
                           (code_reg == $past(code_reg) - 8'h01))
    else $error("ramp moved more than one code");

  chk_ramp_pace: assert property (
    $changed(code_reg) |-> $past(cnt_reg) == $past(interval) - CNT_W'(1))
    else $error("ramp stepped off its pace");
endmodule

// ==== core/pin_sync.sv ====
// module: two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // first stage is read by the second stage only
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// ==== core/ramp_if.sv ====
// interface: target and pace from the bank to one output ramp
`timescale 1ns/1ps
interface ramp_if;
  logic [7:0] target;
  logic [2:0] slew;
  logic [7:0] present;
  logic       busy;
  modport ctrl (output target, output slew, input present, input busy);
  modport ramp (input target, input slew, output present, output busy);
endinterface

// ==== core/regbank_pkg.sv ====
// package: register map, field layout and code tables of the setpoint bank
package regbank_pkg;
  // --------------------------------------------------------------------
  // clock and bus
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_MHZ       = 1000 / CLK_PERIOD_NS;
  localparam int ADDR_W        = 8;

  // register indices; the byte address is four times the index
  localparam logic [7:0] TUNING_IDX  = 8'h05;
  localparam logic [7:0] FIRST_IDX   = 8'h06;
  localparam logic [7:0] SECOND_IDX  = 8'h07;
  localparam logic [7:0] STEP_UP_IDX = 8'h08;
  localparam logic [7:0] STATUS_IDX  = 8'h0F;

  // hardwired reset values, overlaid by one-time memory at boot
  localparam logic [7:0] TUNING_RESET  = 8'h1A;
  localparam logic [7:0] VOUT_RESET    = 8'h00;
  localparam logic [7:0] STEP_UP_RESET = 8'h18;
  localparam logic [7:0] TUNING_OTP    = 8'h3F;
  localparam logic [7:0] STEP_UP_OTP   = 8'hC7;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int ILIM_LSB = 3;
  localparam int SLEW_LSB = 0;
  localparam int SU_V_LSB = 6;
  localparam int RDIS_BIT = 3;
  localparam int PIN_LSB  = 1;
  localparam int EN_BIT   = 0;

  localparam logic [2:0] ILIM_RESERVED = 3'h7;
  localparam logic [2:0] SLEW_FIRST_OK = 3'h2;
  localparam logic [3:0] ILIM_BASE     = 4'h3;  // 1.5 A in 0.5 A units
  localparam logic [3:0] LIMIT_RESET   = 4'h6;  // 3.0 A
  localparam logic [5:0] SU_BASE       = 6'h31; // 4.9 V in 0.1 V units

  // voltage code segments; levels are in 5 mV units
  localparam logic [7:0] SEG1_CODE = 8'h14;
  localparam logic [7:0] SEG2_CODE = 8'h18;
  localparam logic [7:0] SEG3_CODE = 8'h9E;
  localparam logic [9:0] LVL_OFF   = 10'h000;
  localparam logic [9:0] LVL_SEG1  = 10'h08C;  // 0.700 V
  localparam logic [9:0] LVL_SEG2  = 10'h093;  // 0.735 V
  localparam logic [9:0] LVL_SEG3  = 10'h11C;  // 1.420 V
  localparam logic [9:0] LVL_TOP   = 10'h2A0;  // 3.360 V
  localparam int STEP_UV_COARSE = 10000;
  localparam int STEP_UV_FINE   = 5000;
  localparam int STEP_UV_WIDE   = 20000;

  localparam logic [1:0] BOOT_WAIT = 2'h2;

  typedef enum logic {st_boot = 1'b0, st_run = 1'b1} boot_state_type;

  // code to target level in 5 mV units; reserved low codes give zero
  function automatic logic [9:0] code_to_level(input logic [7:0] c);
    if (c < SEG1_CODE) return LVL_OFF;
    else if (c < SEG2_CODE) return LVL_SEG1 + 10'({c - SEG1_CODE, 1'b0});
    else if (c < SEG3_CODE) return LVL_SEG2 + 10'(c - SEG2_CODE);
    else return LVL_SEG3 + 10'({c - SEG3_CODE, 2'b00});
  endfunction

  // size of one code step of the present segment
  function automatic int step_uv(input logic [7:0] c);
    if (c < SEG2_CODE) return STEP_UV_COARSE;
    else if (c < SEG3_CODE) return STEP_UV_FINE;
    else return STEP_UV_WIDE;
  endfunction

  // ramp code to slope in microvolts per microsecond
  function automatic int rate_uv(input logic [2:0] s);
    case (s)
      3'h3:    return 7500;
      3'h4:    return 3800;
      3'h5:    return 1900;
      3'h6:    return 940;
      3'h7:    return 470;
      default: return 10000;
    endcase
  endfunction

  // cycles per code step, rounded down, never below one
  function automatic logic [10:0] ramp_interval(input logic [7:0] c,
                                                input logic [2:0] s);
    int n;
    n = step_uv(c) * CLK_MHZ / rate_uv(s);
    return (n < 1) ? 11'h001 : 11'(n);
  endfunction
endpackage

// ==== core/regulator_setpoint_registers.sv ====
// module: APB setpoint register bank for two step-down and one step-up
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module regulator_setpoint_registers #(
  parameter logic [2:0] FIRST_SLEW = 3'h2,
  parameter int         RAMP_CNT_W = 11
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        enable_pin_one,
  input  wire logic        enable_pin_two,
  input  wire logic        enable_pin_three,
  input  wire logic [7:0]  otp_tuning,
  input  wire logic [7:0]  otp_first_code,
  input  wire logic [7:0]  otp_second_code,
  input  wire logic [7:0]  otp_step_up,
  output logic      [9:0]  first_level,
  output logic      [9:0]  second_level,
  output logic      [3:0]  second_peak_current_limit,
  output logic      [5:0]  step_up_level,
  output logic             step_up_on,
  output logic             step_up_discharge
);
  // --------------------------------------------------------------------
  // pin and one-time memory synchronisers
  // --------------------------------------------------------------------
  localparam int SYNC_W = 35;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic [2:0]        pins;
  logic [7:0]        otp_tun;
  logic [7:0]        otp_v1;
  logic [7:0]        otp_v2;
  logic [7:0]        otp_su;

  // memory words are static, but still cross in like any pin
  assign sync_in = {otp_step_up, otp_second_code, otp_first_code,
                    otp_tuning, enable_pin_three, enable_pin_two,
                    enable_pin_one};
  assign {otp_su, otp_v2, otp_v1, otp_tun, pins} = sync_out;

  pin_sync #(.W(SYNC_W)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    return a == {idx[5:0], 2'b00};
  endfunction

  // pin selected by the gating field, 1 when no pin is selected
  function automatic logic gate(input logic [1:0] sel,
                                input logic [2:0] p);
    case (sel)
      2'h1:    return p[0];
      2'h2:    return p[1];
      2'h3:    return p[2];
      default: return 1'b1;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  regbank_pkg::boot_state_type state_reg;
  regbank_pkg::boot_state_type state_next;
  logic [1:0]  boot_cnt_reg;
  logic [1:0]  boot_cnt_next;
  logic [7:0]  tuning_reg;
  logic [7:0]  tuning_next;
  logic [7:0]  first_code_reg;
  logic [7:0]  first_code_next;
  logic [7:0]  second_code_reg;
  logic [7:0]  second_code_next;
  logic [7:0]  step_up_reg;
  logic [7:0]  step_up_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [9:0]  first_level_reg;
  logic [9:0]  first_level_next;
  logic [9:0]  second_level_reg;
  logic [9:0]  second_level_next;
  logic [3:0]  limit_reg;
  logic [3:0]  limit_next;
  logic [5:0]  su_level_reg;
  logic [5:0]  su_level_next;
  logic        su_on_reg;
  logic        su_on_next;
  logic        discharge_reg;
  logic        discharge_next;
  logic        wr;
  logic [7:0]  rd_data;
  logic        rd_err;
  logic [2:0]  ilim;
  logic [2:0]  slew;

  ramp_if ramp_first ();
  ramp_if ramp_second ();

  // --------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------
  // a write lands on the edge that samples pready high
  assign wr = psel & penable & pready_reg & pwrite & pstrb[0];

  // read mux; unmapped or misaligned addresses answer with an error
  always_comb begin
    rd_data = 8'h00;
    rd_err  = 1'b0;
    if (hit(paddr, regbank_pkg::TUNING_IDX)) rd_data = tuning_reg;
    else if (hit(paddr, regbank_pkg::FIRST_IDX)) rd_data = first_code_reg;
    else if (hit(paddr, regbank_pkg::SECOND_IDX)) rd_data = second_code_reg;
    else if (hit(paddr, regbank_pkg::STEP_UP_IDX)) rd_data = step_up_reg;
    else if (hit(paddr, regbank_pkg::STATUS_IDX))
      rd_data = {4'h0, ramp_second.busy, ramp_first.busy,
                 discharge_reg, su_on_reg};
    else rd_err = 1'b1;
  end

  // one wait state; held off until the boot load is done
  always_comb begin
    pready_next  = psel & penable & ~pready_reg &
                   (state_reg == regbank_pkg::st_run);
    prdata_next  = pready_next ? {24'h000000, rd_data} : prdata_reg;
    pslverr_next = pready_next & rd_err;
  end

  // --------------------------------------------------------------------
  // boot load and register writes
  // --------------------------------------------------------------------
  // memory defaults are taken once the synchronisers hold valid data
  always_comb begin
    state_next       = state_reg;
    boot_cnt_next    = boot_cnt_reg;
    tuning_next      = tuning_reg;
    first_code_next  = first_code_reg;
    second_code_next = second_code_reg;
    step_up_next     = step_up_reg;
    case (state_reg)
      regbank_pkg::st_boot: begin
        boot_cnt_next = boot_cnt_reg + 2'h1;
        if (boot_cnt_reg == regbank_pkg::BOOT_WAIT) begin
          state_next       = regbank_pkg::st_run;
          tuning_next      = (tuning_reg & ~regbank_pkg::TUNING_OTP) |
                             (otp_tun & regbank_pkg::TUNING_OTP);
          first_code_next  = otp_v1;
          second_code_next = otp_v2;
          step_up_next     = (step_up_reg & ~regbank_pkg::STEP_UP_OTP) |
                             (otp_su & regbank_pkg::STEP_UP_OTP);
        end
      end
      regbank_pkg::st_run: begin
        // every bit is writable; reserved bits are stored as written
        if (wr && hit(paddr, regbank_pkg::TUNING_IDX)) begin
          tuning_next = pwdata[7:0];
        end
        if (wr && hit(paddr, regbank_pkg::FIRST_IDX)) begin
          first_code_next = pwdata[7:0];
        end
        if (wr && hit(paddr, regbank_pkg::SECOND_IDX)) begin
          second_code_next = pwdata[7:0];
        end
        if (wr && hit(paddr, regbank_pkg::STEP_UP_IDX)) begin
          step_up_next = pwdata[7:0];
        end
      end
      default: state_next = regbank_pkg::st_boot;
    endcase
  end

  // --------------------------------------------------------------------
  // decoded controls
  // --------------------------------------------------------------------
  assign ilim = tuning_reg[regbank_pkg::ILIM_LSB +: 3];
  // reserved slope codes fall back to the fastest defined slope
  assign slew = (tuning_reg[regbank_pkg::SLEW_LSB +: 3] <
                 regbank_pkg::SLEW_FIRST_OK) ? regbank_pkg::SLEW_FIRST_OK :
                tuning_reg[regbank_pkg::SLEW_LSB +: 3];

  assign ramp_first.target  = first_code_reg;
  assign ramp_first.slew    = FIRST_SLEW;
  assign ramp_second.target = second_code_reg;
  assign ramp_second.slew   = slew;

  code_ramp #(.CNT_W(RAMP_CNT_W)) u_ramp_first (
    .pclk    (pclk),
    .presetn (presetn),
    .rp      (ramp_first)
  );

  code_ramp #(.CNT_W(RAMP_CNT_W)) u_ramp_second (
    .pclk    (pclk),
    .presetn (presetn),
    .rp      (ramp_second)
  );

  // the reserved limit code keeps the last valid limit in force
  always_comb begin
    limit_next = (ilim == regbank_pkg::ILIM_RESERVED) ? limit_reg :
                 regbank_pkg::ILIM_BASE + 4'(ilim);
    first_level_next  = regbank_pkg::code_to_level(ramp_first.present);
    second_level_next = regbank_pkg::code_to_level(ramp_second.present);
    su_level_next = regbank_pkg::SU_BASE +
                    6'(step_up_reg[regbank_pkg::SU_V_LSB +: 2]);
    su_on_next = step_up_reg[regbank_pkg::EN_BIT] &
                 gate(step_up_reg[regbank_pkg::PIN_LSB +: 2], pins);
    discharge_next = step_up_reg[regbank_pkg::RDIS_BIT] & ~su_on_next;
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= regbank_pkg::st_boot;
      boot_cnt_reg     <= 2'h0;
      tuning_reg       <= regbank_pkg::TUNING_RESET;
      first_code_reg   <= regbank_pkg::VOUT_RESET;
      second_code_reg  <= regbank_pkg::VOUT_RESET;
      step_up_reg      <= regbank_pkg::STEP_UP_RESET;
      prdata_reg       <= 32'h00000000;
      pready_reg       <= 1'b0;
      pslverr_reg      <= 1'b0;
      first_level_reg  <= regbank_pkg::LVL_OFF;
      second_level_reg <= regbank_pkg::LVL_OFF;
      limit_reg        <= regbank_pkg::LIMIT_RESET;
      su_level_reg     <= regbank_pkg::SU_BASE;
      su_on_reg        <= 1'b0;
      discharge_reg    <= regbank_pkg::STEP_UP_RESET[regbank_pkg::RDIS_BIT];
    end else begin
      state_reg        <= state_next;
      boot_cnt_reg     <= boot_cnt_next;
      tuning_reg       <= tuning_next;
      first_code_reg   <= first_code_next;
      second_code_reg  <= second_code_next;
      step_up_reg      <= step_up_next;
      prdata_reg       <= prdata_next;
      pready_reg       <= pready_next;
      pslverr_reg      <= pslverr_next;
      first_level_reg  <= first_level_next;
      second_level_reg <= second_level_next;
      limit_reg        <= limit_next;
      su_level_reg     <= su_level_next;
      su_on_reg        <= su_on_next;
      discharge_reg    <= discharge_next;
    end
  end

  assign prdata                    = prdata_reg;
  assign pready                    = pready_reg;
  assign pslverr                   = pslverr_reg;
  assign first_level               = first_level_reg;
  assign second_level              = second_level_reg;
  assign second_peak_current_limit = limit_reg;
  assign step_up_level             = su_level_reg;
  assign step_up_on                = su_on_reg;
  assign step_up_discharge         = discharge_reg;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tuning_write;
    wr && hit(paddr, regbank_pkg::TUNING_IDX) &&
    pwdata[5:3] != regbank_pkg::ILIM_RESERVED;
  endsequence
  sequence s_boot_done;
    state_reg == regbank_pkg::st_boot ##1 state_reg == regbank_pkg::st_run;
  endsequence
  chk_limit_decode: assert property (
    (ilim != regbank_pkg::ILIM_RESERVED) |=>
      limit_reg == regbank_pkg::ILIM_BASE + 4'($past(ilim)))
    else $error("peak limit decoded wrong");
  chk_limit_reserved: assert property (
    (ilim == regbank_pkg::ILIM_RESERVED) |=> $stable(limit_reg))
    else $error("reserved limit code changed the limit");
  chk_limit_live: assert property (
    s_tuning_write |-> ##2
      limit_reg == regbank_pkg::ILIM_BASE + 4'($past(pwdata[5:3], 2)))
    else $error("limit write not applied within two cycles");
  chk_level_map: assert property (
    ($past(ramp_first.present) == 8'hFF) |->
      first_level_reg == regbank_pkg::LVL_TOP)
    else $error("top code does not give the top level");
  chk_second_map: assert property (
    second_level_reg == regbank_pkg::code_to_level($past(ramp_second.present)))
    else $error("second level map differs");
  chk_boost_level: assert property (
    su_level_reg == regbank_pkg::SU_BASE + 6'($past(step_up_reg[7:6])))
    else $error("step-up level decoded wrong");
  chk_discharge_off: assert property (
    step_up_discharge |-> !step_up_on && $past(step_up_reg[3]))
    else $error("discharge while on or not enabled");
  chk_pin_gating: assert property (
    ($past(step_up_reg[2:0]) == 3'h3 && !$past(pins[0])) ||
    !$past(step_up_reg[0]) |-> !su_on_reg)
    else $error("step-up on against its gating");
  chk_otp_load: assert property (
    s_boot_done |-> first_code_reg == $past(otp_v1) &&
                    second_code_reg == $past(otp_v2))
    else $error("memory defaults not loaded at boot");
endmodule

// ==== verif/testbench.sv ====
// testbench: APB register traffic and port checks for the setpoint bank
`timescale 1ns/1ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pins;
  logic [9:0]  lvl1;
  logic [9:0]  lvl2;
  logic [3:0]  ilim;
  logic [5:0]  su_lvl;
  logic        su_on;
  logic        su_dis;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;

  // one-time memory words are static, so they are tied off
  regulator_setpoint_registers dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_pin_one(pins[0]), .enable_pin_two(pins[1]),
    .enable_pin_three(pins[2]), .otp_tuning(8'h12),
    .otp_first_code(8'h14), .otp_second_code(8'h14),
    .otp_step_up(8'h62), .first_level(lvl1), .second_level(lvl2),
    .second_peak_current_limit(ilim), .step_up_level(su_lvl),
    .step_up_on(su_on), .step_up_discharge(su_dis)
  );

  // ------------------------------------------------------------------
  // clock, timeout and shared tasks
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ramps are slow, so the ceiling allows the full code span up and down on both outputs twice over
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until pready is seen high at a rising edge; a slave
  // that never answers is caught by the bench ceiling, not here
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task boot_values();
    apb(1'b0, 8'h14, 32'h0);
    check("tuning", rd, 32'h12);
    check("read err", er, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("step_up ctrl", rd, 32'h5A);
    check("discharge", su_dis, 32'h1);
    check("step_up level", su_lvl, 32'h32);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", er, 32'h1);
    $display("test boot_values done");
  endtask

  task limit_codes();
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h14, 32'((c << 3) | 2));
      repeat (2) @(posedge pclk);
      check("limit", ilim, (c < 7) ? 32'(c + 3) : 32'h9);
    end
    apb(1'b1, 8'h14, 32'h02);
    $display("test limit_codes done");
  endtask

  task voltage_map();
    logic [7:0] code [7] = '{8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF,
                             8'h14};
    logic [9:0] lv [7] = '{10'h08C, 10'h092, 10'h093, 10'h118, 10'h11C,
                           10'h2A0, 10'h08C};
    int n;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 7; i++) begin
        apb(1'b1, (r == 0) ? 8'h18 : 8'h1C, {24'h0, code[i]});
        repeat (2) @(posedge pclk);
        if (i == 5)
          check("no jump", ((r == 0) ? lvl1 : lvl2) == lv[i], 32'h0);
        n = 0;
        while (((r == 0) ? lvl1 : lvl2) !== lv[i] && n < 8000) begin
          @(posedge pclk);
          n++;
        end
        // three 10 mV steps at 10 mV/us take 75 cycles of 40 ns
        if (i == 1) check("pace", n, 32'h4B);
        check("level", r ? lvl2 : lvl1, lv[i]);
      end
    end
    $display("test voltage_map done");
  endtask

  task step_up_gating();
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 8'h20, 32'((p << 6) | (p << 1) | 8'h19));
      pins <= (p == 0) ? 3'h0 : 3'(1 << (p - 1));
      repeat (4) @(posedge pclk);
      check("on", su_on, 32'h1);
      check("level", su_lvl, 32'(49 + p));
      check("discharge", su_dis, 32'h0);
      pins <= (p == 0) ? 3'h7 : ~3'(1 << (p - 1));
      repeat (4) @(posedge pclk);
      check("gated", su_on, (p == 0) ? 32'h1 : 32'h0);
      check("discharge", su_dis, (p == 0) ? 32'h0 : 32'h1);
    end
    apb(1'b1, 8'h20, 32'h10);
    repeat (4) @(posedge pclk);
    check("off", su_on, 32'h0);
    check("no discharge", su_dis, 32'h0);
    $display("test step_up_gating done");
  endtask

  // main sequence: reset, then each scenario in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pins = 3'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    boot_values();
    limit_codes();
    voltage_map();
    step_up_gating();
    give_verdict();
  end
endmodule
